// ---- rtl/tws_core.sv ----
`default_nettype none
module tws_core #(
   parameter int CFG_DEPTH = 16,
   parameter int MAX_PROTO = 4,
   parameter logic [7:0] PROTO_BASE = 8'h80,
   parameter logic [7:0] LIST_CHANGED_CODE = 8'h01
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [tws_pkg::AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [tws_pkg::AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rx_valid,
   input wire tws_pkg::tws_msg_t rx_msg,
   output logic rx_ready,
   output logic wreq_valid,
   output tws_pkg::tws_wreq_t wreq,
   input wire logic wresp_valid,
   input wire tws_pkg::tws_wresp_t wresp,
   output logic [31:0] buf_addr,
   input wire logic buf_valid,
   input wire logic [31:0] buf_data,
   output logic tx_valid,
   output tws_pkg::tws_frame_t tx_frame,
   input wire logic tx_ready,
   input wire logic xend_valid,
   input wire tws_pkg::tws_xend_t xend,
   output logic wdone_valid,
   output tws_pkg::tws_wdone_t wdone,
   output logic halt_valid,
   output logic [7:0] halt_src,
   input wire logic halt_done,
   input wire logic [7:0] halt_retcode,
   input wire logic total_reset_in,
   input wire logic ext_evt_valid,
   input wire tws_pkg::tws_ext_t ext_evt,
   output logic ext_evt_busy,
   output logic evt_valid,
   output tws_pkg::tws_evt_t evt,
   output logic alert_valid,
   output logic [7:0] alert_code
);
   localparam int IW = $clog2(CFG_DEPTH);

   tws_pkg::tws_state_t state, next_state;
   tws_pkg::tws_msg_t cur;
   tws_pkg::tws_cfg_t cfg_tab [CFG_DEPTH];
   tws_pkg::tws_ext_t ext_q;
   tws_pkg::tws_evt_t sel_evt;
   logic aw_full, w_full;
   logic [tws_pkg::AW-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [15:0] mask_reg, evt_mask;
   logic [31:0] vendor_reg, remaining;
   logic vendor_wide, reg_pend, reg_done, reg_ok;
   logic [IW-1:0] cfg_idx, uid_q, scan_idx;
   logic [7:0] proto_code, reg_count, match_code, hret;
   logic pend_total, pend_local;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic tws_pkg::tws_evt_t mk_evt(input logic [3:0] code,
         input logic info, input logic [63:0] dev,
         input logic [7:0] al, input logic [31:0] fr);
      tws_pkg::tws_evt_t e;
      e.code = code;
      e.info_valid = info;
      e.dev = dev;
      e.alert = al;
      e.frame = fr;
      return e;
   endfunction

   // Register bus decode.
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_full & w_full & ~s_axi_bvalid;
   wire next_aw_full = (aw_full | aw_take) & ~do_write;
   wire next_w_full = (w_full | w_take) & ~do_write;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
   wire [tws_pkg::AW-1:0] wa = {aw_addr_q[tws_pkg::AW-1:2], 2'b00};
   wire [tws_pkg::AW-1:0] ra = {s_axi_araddr[tws_pkg::AW-1:2], 2'b00};
   wire wr_ctrl = do_write & (wa == tws_pkg::REG_CTRL);
   wire wr_mask = do_write & (wa == tws_pkg::REG_MASK);
   wire wr_vendor = do_write & (wa == tws_pkg::REG_VENDOR);
   wire wr_idx = do_write & (wa == tws_pkg::REG_CFG_IDX);
   wire wr_cfg = do_write & (wa == tws_pkg::REG_CFG_DATA);
   wire wr_hit = wr_ctrl | wr_mask | wr_vendor | wr_idx | wr_cfg
      | (wa == tws_pkg::REG_STATUS);
   wire [31:0] ctrl_m = merge(32'h0000_0000, w_data_q, w_strb_q);
   wire reg_go = wr_ctrl & ctrl_m[tws_pkg::CTRL_GO];
   wire lrst = wr_ctrl & ctrl_m[tws_pkg::CTRL_LRST];
   wire [31:0] mask_m = merge({16'h0000, mask_reg}, w_data_q, w_strb_q);
   wire [31:0] idx_m = merge(32'(cfg_idx), w_data_q, w_strb_q);
   wire [31:0] cfg_m = merge(32'(cfg_tab[cfg_idx]), w_data_q, w_strb_q);

   wire [31:0] status_word = {8'h00, reg_count, proto_code, 4'h0,
      state == tws_pkg::S_IDLE, reg_pend, reg_ok, reg_done};
   wire [31:0] rd_word =
      (ra == tws_pkg::REG_CTRL) ? {29'h0, vendor_wide, 2'b00} :
      (ra == tws_pkg::REG_STATUS) ? status_word :
      (ra == tws_pkg::REG_MASK) ? {16'h0000, mask_reg} :
      (ra == tws_pkg::REG_VENDOR) ? vendor_reg :
      (ra == tws_pkg::REG_CFG_IDX) ? 32'(cfg_idx) :
      (ra == tws_pkg::REG_CFG_DATA) ? 32'(cfg_tab[cfg_idx]) :
      32'h0000_0000;
   wire rd_hit = (ra == tws_pkg::REG_CTRL) | (ra == tws_pkg::REG_STATUS)
      | (ra == tws_pkg::REG_MASK) | (ra == tws_pkg::REG_VENDOR)
      | (ra == tws_pkg::REG_CFG_IDX) | (ra == tws_pkg::REG_CFG_DATA);

   // Service sequencing.
   wire rx_take = rx_valid & rx_ready;
   wire reg_take = (state == tws_pkg::S_IDLE) & reg_pend & ~rx_take
      & ~lrst;
   wire reg_can = reg_count < 8'(MAX_PROTO);
   wire can_load = ~tx_valid | tx_ready;
   wire last_word = remaining <= tws_pkg::WORD_BYTES;
   wire load_data = (state == tws_pkg::S_WSEND) & can_load & buf_valid;
   wire load_halt = (state == tws_pkg::S_HRESP) & can_load;
   wire resp_ok = wresp_valid & wresp.ok;
   wire [IW-1:0] resp_uid = wresp.uid[IW-1:0];

   // Event gating: mask bit and defined code must both be set.
   wire [15:0] ev_en = evt_mask & tws_pkg::EV_DEFINED;
   wire en_total = ev_en[tws_pkg::EV_TOTAL];
   wire en_local = ev_en[tws_pkg::EV_LOCAL];
   wire en_ext = ev_en[ext_evt.code];
   wire en_newdev = ev_en[tws_pkg::EV_NEWDEV];
   wire pend_ext = ext_evt_busy;
   wire pend_any = pend_total | pend_local | pend_ext;
   wire dlv_total = pend_total;
   wire dlv_local = pend_local & ~pend_total;
   wire dlv_ext = pend_ext & ~pend_total & ~pend_local;
   wire scan_match = cfg_tab[scan_idx].present
      & (cfg_tab[scan_idx].proto == match_code);
   wire scan_step = (state == tws_pkg::S_SCAN) & ~pend_any;
   wire dlv_scan = scan_step & scan_match & en_newdev;
   wire scan_last = scan_idx == IW'(CFG_DEPTH - 1);
   wire ext_take = ext_evt_valid & ~ext_evt_busy;
   wire next_pend_ext = (ext_take & en_ext) | (pend_ext & ~dlv_ext);
   wire [63:0] scan_dev = 64'(scan_idx);

   // Reset reports carry no valid device, alert or frame data.
   assign sel_evt = dlv_total ?
         mk_evt(tws_pkg::EV_TOTAL, 1'b0, 64'h0, 8'h00, 32'h0) :
      dlv_local ?
         mk_evt(tws_pkg::EV_LOCAL, 1'b0, 64'h0, 8'h00, 32'h0) :
      dlv_ext ?
         mk_evt(ext_q.code, 1'b1, ext_q.dev, ext_q.alert, ext_q.frame) :
         mk_evt(tws_pkg::EV_NEWDEV, 1'b1, scan_dev, 8'h00, 32'h0);

   always_comb begin
      next_state = state;
      unique case (state)
         tws_pkg::S_IDLE: begin
            if (rx_take) begin
               next_state = rx_msg.is_halt ? tws_pkg::S_HALT
                                           : tws_pkg::S_WREQ;
            end else if (reg_take && reg_can) begin
               next_state = tws_pkg::S_SCAN;
            end
         end
         tws_pkg::S_WREQ: begin
            if (wresp_valid) begin
               // A failed return ends the service with nothing sent.
               next_state = (resp_ok && cur.byte_count != 32'h0)
                  ? tws_pkg::S_WSEND : tws_pkg::S_IDLE;
            end
         end
         tws_pkg::S_WSEND: begin
            if (load_data && last_word) begin
               next_state = tws_pkg::S_IDLE;
            end
         end
         tws_pkg::S_HALT: begin
            if (halt_done) begin
               next_state = tws_pkg::S_HRESP;
            end
         end
         tws_pkg::S_HRESP: begin
            if (can_load) begin
               next_state = tws_pkg::S_IDLE;
            end
         end
         tws_pkg::S_SCAN: begin
            if (scan_step && scan_last) begin
               next_state = tws_pkg::S_ALERT;
            end
         end
         tws_pkg::S_ALERT: begin
            next_state = tws_pkg::S_IDLE;
         end
      endcase
      // A local reset abandons whatever service was under way.
      if (lrst) begin
         next_state = tws_pkg::S_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tws_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= tws_pkg::RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= ~next_aw_full;
         s_axi_wready <= ~next_w_full;
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? tws_pkg::RESP_OKAY
                                  : tws_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= ~next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? tws_pkg::RESP_OKAY
                                  : tws_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         mask_reg <= tws_pkg::MASK_RST;
         vendor_reg <= 32'h0;
         vendor_wide <= 1'b0;
         cfg_idx <= '0;
         for (int i = 0; i < CFG_DEPTH; i++) begin
            cfg_tab[i] <= '0;
         end
      end else begin
         if (wr_ctrl && w_strb_q[0]) begin
            vendor_wide <= w_data_q[tws_pkg::CTRL_WIDE];
         end
         if (wr_mask) begin
            mask_reg <= mask_m[15:0];
         end
         if (wr_vendor) begin
            vendor_reg <= merge(vendor_reg, w_data_q, w_strb_q);
         end
         if (wr_idx) begin
            cfg_idx <= idx_m[IW-1:0];
         end
         if (wr_cfg) begin
            cfg_tab[cfg_idx] <= tws_pkg::tws_cfg_t'(cfg_m[17:0]);
         end
      end
   end

   // Registration: the mask only takes effect once registration succeeds.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_pend <= 1'b0;
         reg_done <= 1'b0;
         reg_ok <= 1'b0;
         reg_count <= 8'h00;
         proto_code <= 8'h00;
         match_code <= 8'h00;
         evt_mask <= tws_pkg::MASK_RST;
      end else begin
         reg_pend <= reg_go | (reg_pend & ~reg_take);
         if (reg_take) begin
            reg_done <= 1'b1;
            reg_ok <= reg_can;
            if (reg_can) begin
               proto_code <= PROTO_BASE + reg_count;
               match_code <= vendor_wide ? PROTO_BASE + reg_count
                                         : vendor_reg[7:0];
               evt_mask <= mask_reg;
               reg_count <= reg_count + 8'h01;
            end
         end else if (reg_go) begin
            reg_done <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state <= tws_pkg::S_IDLE;
         rx_ready <= 1'b1;
         cur <= '0;
         wreq_valid <= 1'b0;
         wreq <= '0;
         halt_valid <= 1'b0;
         halt_src <= 8'h00;
         hret <= 8'h00;
         uid_q <= '0;
         buf_addr <= 32'h0;
         remaining <= 32'h0;
         scan_idx <= '0;
         alert_valid <= 1'b0;
         alert_code <= 8'h00;
      end else begin
         state <= next_state;
         rx_ready <= next_state == tws_pkg::S_IDLE;
         wreq_valid <= next_state == tws_pkg::S_WREQ;
         halt_valid <= next_state == tws_pkg::S_HALT;
         if (rx_take) begin
            cur <= rx_msg;
            wreq <= '{rx_msg.tag, rx_msg.byte_count,
                      rx_msg.byte_offset};
            halt_src <= rx_msg.source_id;
         end
         if (halt_done) begin
            hret <= halt_retcode;
         end
         if (state == tws_pkg::S_WREQ && resp_ok) begin
            uid_q <= resp_uid;
            buf_addr <= wresp.buf_addr;
            remaining <= cur.byte_count;
         end else if (load_data) begin
            buf_addr <= buf_addr + tws_pkg::WORD_BYTES;
            remaining <= last_word ? 32'h0
                                   : remaining - tws_pkg::WORD_BYTES;
         end
         if (state == tws_pkg::S_IDLE) begin
            scan_idx <= '0;
         end else if (scan_step) begin
            scan_idx <= scan_idx + IW'(1);
         end
         alert_valid <= state == tws_pkg::S_ALERT;
         alert_code <= LIST_CHANGED_CODE;
      end
   end

   // Frames out; underrun simply withholds the next frame.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tx_valid <= 1'b0;
         tx_frame <= '0;
      end else if (load_data) begin
         tx_valid <= 1'b1;
         tx_frame.ctrl <= tws_pkg::FRAME_CTRL;
         tx_frame.path <= cfg_tab[uid_q].path;
         tx_frame.channel <= cur.channel;
         tx_frame.port <= cfg_tab[uid_q].port;
         tx_frame.is_resp <= 1'b0;
         tx_frame.msg_code <= 8'h00;
         tx_frame.ret_code <= 8'h00;
         tx_frame.nbytes <= last_word ? remaining[2:0] : 3'h4;
         tx_frame.data <= buf_data;
      end else if (load_halt) begin
         tx_valid <= 1'b1;
         tx_frame.ctrl <= tws_pkg::FRAME_CTRL;
         tx_frame.path <= cur.return_path;
         tx_frame.channel <= tws_pkg::CH_ZERO;
         tx_frame.port <= cur.port;
         tx_frame.is_resp <= 1'b1;
         tx_frame.msg_code <= tws_pkg::HALT_RESP_CODE;
         tx_frame.ret_code <= hret;
         tx_frame.nbytes <= 3'h0;
         tx_frame.data <= 32'h0;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end

   // Completion: a retried but recovered transfer still counts as good.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wdone_valid <= 1'b0;
         wdone <= '0;
      end else begin
         wdone_valid <= xend_valid;
         if (xend_valid) begin
            wdone <= '{xend.tag, xend.uid, xend.logical_unit,
                       ~xend.overrun & ~xend.erp_failed};
         end
      end
   end

   // Events are checked in every state, so they pre-empt the scan.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pend_total <= 1'b0;
         pend_local <= 1'b0;
         ext_evt_busy <= 1'b0;
         ext_q <= '0;
         evt_valid <= 1'b0;
         evt <= '0;
      end else begin
         pend_total <= (total_reset_in & en_total)
            | (pend_total & ~dlv_total);
         pend_local <= (lrst & en_local) | (pend_local & ~dlv_local);
         ext_evt_busy <= next_pend_ext;
         if (ext_take) begin
            ext_q <= ext_evt;
         end
         evt_valid <= pend_any | dlv_scan;
         evt <= sel_evt;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tws_pkg.sv ----
`default_nettype none
package tws_pkg;
   localparam int AW = 8;
   // Register byte offsets.
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_STATUS = 8'h04;
   localparam logic [AW-1:0] REG_MASK = 8'h08;
   localparam logic [AW-1:0] REG_VENDOR = 8'h0c;
   localparam logic [AW-1:0] REG_CFG_IDX = 8'h10;
   localparam logic [AW-1:0] REG_CFG_DATA = 8'h14;
   // Control bits.
   localparam int CTRL_GO = 0;
   localparam int CTRL_LRST = 1;
   localparam int CTRL_WIDE = 2;
   // Status bits.
   localparam int ST_DONE = 0;
   localparam int ST_OK = 1;
   localparam int ST_PEND = 2;
   localparam int ST_IDLE = 3;
   localparam int ST_CODE = 8;
   localparam int ST_COUNT = 16;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Frame constants.
   localparam logic [7:0] FRAME_CTRL = 8'h00;
   localparam logic [7:0] CH_ZERO = 8'h00;
   localparam logic [7:0] HALT_RESP_CODE = 8'h03;
   // Event codes and the set of defined codes.
   localparam logic [3:0] EV_LOCAL = 4'h0;
   localparam logic [3:0] EV_TOTAL = 4'h1;
   localparam logic [3:0] EV_NEWDEV = 4'h4;
   localparam logic [3:0] EV_LOST = 4'h5;
   localparam logic [3:0] EV_PATH = 4'h6;
   localparam logic [3:0] EV_INVALID = 4'h8;
   localparam logic [3:0] EV_ENV = 4'h9;
   localparam logic [3:0] EV_WARN = 4'ha;
   localparam logic [15:0] EV_DEFINED = 16'h0773;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_WREQ = 7'b0000010,
      S_WSEND = 7'b0000100,
      S_HALT = 7'b0001000,
      S_HRESP = 7'b0010000,
      S_SCAN = 7'b0100000,
      S_ALERT = 7'b1000000
   } tws_state_t;

   typedef struct packed {
      logic is_halt;
      logic [15:0] tag;
      logic [31:0] byte_count;
      logic [31:0] byte_offset;
      logic [7:0] channel;
      logic [7:0] source_id;
      logic [7:0] return_path;
      logic port;
   } tws_msg_t;

   typedef struct packed {
      logic [15:0] tag;
      logic [31:0] byte_count;
      logic [31:0] byte_offset;
   } tws_wreq_t;

   typedef struct packed {
      logic ok;
      logic [7:0] uid;
      logic [31:0] buf_addr;
   } tws_wresp_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] path;
      logic [7:0] channel;
      logic port;
      logic is_resp;
      logic [7:0] msg_code;
      logic [7:0] ret_code;
      logic [2:0] nbytes;
      logic [31:0] data;
   } tws_frame_t;

   typedef struct packed {
      logic [15:0] tag;
      logic [7:0] uid;
      logic [7:0] logical_unit;
      logic overrun;
      logic erp_failed;
   } tws_xend_t;

   typedef struct packed {
      logic [15:0] tag;
      logic [7:0] uid;
      logic [7:0] logical_unit;
      logic ok;
   } tws_wdone_t;

   typedef struct packed {
      logic [3:0] code;
      logic [63:0] dev;
      logic [7:0] alert;
      logic [31:0] frame;
   } tws_ext_t;

   typedef struct packed {
      logic [3:0] code;
      logic info_valid;
      logic [63:0] dev;
      logic [7:0] alert;
      logic [31:0] frame;
   } tws_evt_t;

   typedef struct packed {
      logic present;
      logic port;
      logic [7:0] proto;
      logic [7:0] path;
   } tws_cfg_t;
endpackage
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, nrst = 0, rx_valid = 0, wresp_valid = 0, xend_valid = 0;
   logic halt_done = 0, total_reset_in = 0, ext_evt_valid = 0, rx_ready;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_bvalid;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_arready, s_axi_rvalid, wreq_valid, buf_valid, tx_valid;
   logic tx_ready, wdone_valid, halt_valid, ext_evt_busy, evt_valid;
   logic alert_valid;
   logic [tws_pkg::AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [7:0] halt_retcode = 0, halt_src, alert_code, aq[$];
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, buf_addr, buf_data, rd;
   tws_pkg::tws_msg_t rx_msg = '0;
   tws_pkg::tws_wreq_t wreq;
   tws_pkg::tws_wresp_t wresp = '0;
   tws_pkg::tws_frame_t tx_frame, fq[$];
   tws_pkg::tws_xend_t xend = '0;
   tws_pkg::tws_wdone_t wdone;
   tws_pkg::tws_ext_t ext_evt = '0;
   tws_pkg::tws_evt_t evt, eq[$];
   int miscompares = 0, n_checks = 0, i, k;
   tws_core dut (.*);
   tws_node node (.*);
   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (tx_valid && tx_ready) fq.push_back(tx_frame);
      if (evt_valid) eq.push_back(evt);
      if (alert_valid) aq.push_back(alert_code);
   end
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // A wait that used up its bound counts as a mismatch and ends the run.
   task automatic give_up(input bit hit);
      if (hit) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge clock);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      for (j = 0; j < 50; j++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_bvalid || s_axi_rvalid) break;
      end
      {s_axi_bready, s_axi_rready} <= 2'h0;
      rd = s_axi_rdata;
      rr = w ? s_axi_bresp : s_axi_rresp;
      give_up(j == 50);
   endtask
   // Waits for the service request or the halt request that follows.
   task automatic send(input tws_pkg::tws_msg_t m);
      @(posedge clock);
      rx_msg <= m;
      rx_valid <= 1;
      @(posedge clock);
      for (i = 0; i < 50 && !rx_ready; i++) @(posedge clock);
      give_up(i == 50);
      rx_valid <= 0;
      for (i = 0; i < 50 && !(wreq_valid || halt_valid); i++)
         @(posedge clock);
      give_up(i == 50);
   endtask
   task automatic answer(input tws_pkg::tws_wresp_t r);
      fq.delete();
      wresp <= r;
      wresp_valid <= 1;
      @(posedge clock);
      wresp_valid <= 0;
      repeat (40) @(posedge clock);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      nrst <= 1;
      axi(0, tws_pkg::REG_MASK, '0);
      check(rd, 16'h0000);
      axi(0, 8'h40, '0);
      check(rr, 2'h2);
      total_reset_in <= 1;
      @(posedge clock);
      total_reset_in <= 0;
      repeat (4) @(posedge clock);
      check(eq.size(), 0);
      for (i = 1; i < 4; i++) begin
         axi(1, tws_pkg::REG_CFG_IDX, i);
         axi(1, tws_pkg::REG_CFG_DATA,
             {14'h0, 2'h2, i == 2 ? 8'h81 : 8'h55, 8'h20 + i[7:0]});
      end
      axi(1, tws_pkg::REG_VENDOR, 32'h55);
      axi(1, tws_pkg::REG_MASK, 32'hffff);
      axi(1, tws_pkg::REG_CTRL, 32'h1);
      for (i = 0; i < 300 && aq.size() == 0; i++) @(posedge clock);
      give_up(i == 300);
      axi(0, tws_pkg::REG_STATUS, '0);
      check({rd[15:8], rd[1]}, {8'h80, 1'h1});
      check(eq.size(), 2);
      check({eq[0].code, eq[0].dev}, {4'h4, 64'h1});
      check({eq[1].code, eq[1].dev}, {4'h4, 64'h3});
      check(aq[0], 8'h01);
      $display("registration done");
      eq.delete();
      total_reset_in <= 1;
      @(posedge clock);
      total_reset_in <= 0;
      for (k = 2; k < 16; k++) begin
         ext_evt <= {k[3:0], 64'h1, 8'h42, 32'h9};
         ext_evt_valid <= 1;
         @(posedge clock);
         for (i = 0; i < 50 && ext_evt_busy; i++) @(posedge clock);
         give_up(i == 50);
         ext_evt_valid <= 0;
         @(posedge clock);
      end
      repeat (4) @(posedge clock);
      check(eq.size(), 7);
      check({eq[0].code, eq[0].info_valid}, {4'h1, 1'h0});
      check({eq[1].dev, eq[1].alert, eq[1].frame},
            {64'h1, 8'h42, 32'h9});
      i = 1;
      for (k = 2; k < 16; k++)
         if (16'h0773 >> k & 16'h1) check(eq[i++].code, k[3:0]);
      $display("events done");
      send({1'h0, 16'h1234, 32'ha, 32'h8, 8'h07, 17'h0});
      check(wreq, {16'h1234, 32'ha, 32'h8});
      answer({1'h1, 8'h01, 32'h100});
      check(fq.size(), 3);
      for (k = 0; k < 3; k++)
         check({fq[k].path, fq[k].channel, fq[k].nbytes, fq[k].data},
               {16'h2107, k < 2 ? 3'h4 : 3'h2,
                32'h5a5a5b5a ^ 32'(4 * k)});
      send({1'h0, 16'h4321, 32'h8, 32'h0, 8'h07, 17'h0});
      // The protocol layer ends its own process after this.
      answer({1'h0, 8'h01, 32'h200});
      check({fq.size(), rx_ready}, {32'h0, 1'h1});
      $display("write service done");
      send({1'h1, 88'h0, 8'h44, 8'h33, 1'h1});
      check(halt_src, 8'h44);
      halt_retcode <= 8'h5a;
      halt_done <= 1;
      @(posedge clock);
      halt_done <= 0;
      for (i = 0; i < 50 && fq.size() == 0; i++) @(posedge clock);
      give_up(i == 50);
      check({fq[0].path, fq[0].channel, fq[0].port, fq[0].msg_code,
             fq[0].ret_code}, {16'h3300, 1'h1, 16'h035a});
      for (k = 0; k < 3; k++) begin
         xend <= {16'h77, 8'h2, 8'h5, k == 1, k == 2};
         xend_valid <= 1;
         @(posedge clock);
         xend_valid <= 0;
         @(posedge clock);
         check({wdone_valid, wdone},
               {1'h1, 32'h770205, k == 0});
      end
      $display("halt and completion done");
      eq.delete();
      axi(1, tws_pkg::REG_CTRL, 32'h2);
      check(rr, 2'h0);
      repeat (4) @(posedge clock);
      check({eq.size(), eq[0].code}, {32'h1, 4'h0});
      check(eq[0].info_valid, 1'h0);
      // Wide vendor code: the scan matches on the newly assigned code.
      eq.delete();
      aq.delete();
      axi(1, tws_pkg::REG_CTRL, 32'h5);
      for (i = 0; i < 300 && aq.size() == 0; i++) @(posedge clock);
      give_up(i == 300);
      axi(0, tws_pkg::REG_STATUS, '0);
      check(rd[23:8], 16'h0281);
      check({eq.size(), eq[0].dev}, {32'h1, 64'h2});
      $display("local reset and wide registration done");
      test_done();
   end
endmodule
`default_nettype wire

// ---- tb/tws_chk_assertions.sv ----
`default_nettype none
module tws_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire logic buf_valid,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire tws_pkg::tws_frame_t tx_frame,
   input wire logic xend_valid,
   input wire tws_pkg::tws_xend_t xend,
   input wire logic wdone_valid,
   input wire tws_pkg::tws_wdone_t wdone,
   input wire logic evt_valid,
   input wire tws_pkg::tws_evt_t evt
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   a_done_ids: assert property (
      xend_valid |=> wdone_valid && wdone.tag == $past(xend.tag) &&
      wdone.uid == $past(xend.uid) &&
      wdone.logical_unit == $past(xend.logical_unit)) else $error("ids");
   a_done_ok: assert property (
      xend_valid |=> wdone.ok ==
      !($past(xend.overrun) || $past(xend.erp_failed))) else $error("ok");
   a_ctrl_zero: assert property (
      tx_valid |-> tx_frame.ctrl == 8'h00) else $error("ctrl");
   a_resp_code: assert property (
      tx_valid && tx_frame.is_resp |-> tx_frame.msg_code == 8'h03 &&
      tx_frame.channel == 8'h00) else $error("resp");
   a_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
      else $error("hold");
   a_no_underrun: assert property (
      $rose(tx_valid) && !tx_frame.is_resp |-> $past(buf_valid))
      else $error("underrun");
   a_no_reserved: assert property (
      evt_valid |-> tws_pkg::EV_DEFINED[evt.code]) else $error("code");
   a_reset_info: assert property (
      evt_valid && evt.code <= 4'h1 |-> !evt.info_valid) else $error("info");
   c_fail: cover property (wdone_valid && !wdone.ok);
   c_resp: cover property (tx_valid && tx_frame.is_resp);
   c_newdev: cover property (evt_valid && evt.code == 4'h4);
endmodule
bind tws_core tws_chk u_chk (.*);
`default_nettype wire

// ---- tb/tws_node.sv ----
`default_nettype none
module tws_node (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [31:0] buf_addr,
   output logic buf_valid,
   output logic [31:0] buf_data,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] t;
   // Words follow the address so payloads are predictable; one cycle in
   // four is an underrun and the link stalls every other cycle.
   always_ff @(posedge clock) begin
      t <= nrst ? t + 4'h1 : 4'h0;
      buf_valid <= t[1:0] != 2'h3;
      tx_ready <= t[0];
   end
   assign buf_data = {32{!buf_valid}} ^ buf_addr ^ 32'h5a5a5a5a;
endmodule
`default_nettype wire
